// *** inc/tes_pkg.sv ***
/*
 * shared constants for the timer event status block: register offsets,
 * status bit positions, reset values and control register layout.
 * assumes a plain word-addressed register port with 32-bit data.
 */
`default_nettype none
package tes_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] OFS_CHAN3_STATUS = 32'hFFFFF174;
    localparam logic [31:0] OFS_CHAN4_STATUS = 32'hFFFFF184;
    localparam logic [31:0] OFS_CHAN5_STATUS = 32'hFFFFF194;
    localparam logic [31:0] OFS_CHAN6_STATUS = 32'hFFFFF1A4;
    localparam logic [31:0] OFS_CHAN7_STATUS = 32'hFFFFF1B4;
    localparam logic [31:0] OFS_CHAN_STRIDE = 32'h00000010;
    localparam logic [31:0] OFS_MODE_CTRL = 32'hFFFFF240;
    localparam logic [31:0] OFS_IRQ_STATUS = 32'hFFFFF244;
    localparam logic [31:0] OFS_IRQ_MASK = 32'hFFFFF248;
    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int BIT_CMP0 = 0;
    localparam int BIT_CMP1 = 1;
    localparam int BIT_OVF = 2;
    localparam int BIT_UDF = 3;
    localparam int BIT_STEP = 4;
    localparam int BIT_UDCE = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int NUM_CHAN = 5;
    localparam int IRQ_W = 8;
    // interrupt status layout: bits 0..4 = any event of chan 3..7
    localparam logic [IRQ_W-1:0] IRQ_RESET = 8'h00;
endpackage
`default_nettype wire

// *** logic/tes_event_status.sv ***
/*
 * event status flags for timer channels three to seven, with a mode
 * control register, sticky interrupt status and mask.
 * assumes counters and compare logic elsewhere supply one-cycle event
 * pulses on core_clk_i; the register port is driven synchronously.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module tes_event_status #(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // timer events, one-cycle pulses, index 0 is channel three
    input wire logic [tes_pkg::NUM_CHAN-1:0] compare0_match_i,
    input wire logic [tes_pkg::NUM_CHAN-1:0] compare1_match_i,
    input wire logic [tes_pkg::NUM_CHAN-1:0] upcount_overflow_i,
    // channel three up/down counter events
    input wire logic count_step_i,
    input wire logic updown_underflow_i,
    input wire logic updown_overflow_i,
    // mode and interrupt
    output logic updown_count_enable_o,
    output logic updown_overflow_event_o,
    output logic irq_o
);
    localparam int N = tes_pkg::NUM_CHAN;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] status [N];
    logic [7:0] next_status [N];
    logic updown_count_enable;
    logic next_updown_count_enable;
    logic [tes_pkg::IRQ_W-1:0] irq_status;
    logic [tes_pkg::IRQ_W-1:0] next_irq_status;
    logic [tes_pkg::IRQ_W-1:0] irq_mask;
    logic [tes_pkg::IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_rdata;
    logic next_irq;
    logic next_ovf_event;
    logic [N-1:0] chan_event;

    // ------------------------------------------------------------
    // status flags per channel
    // ------------------------------------------------------------
    // flags are sticky events from the timer; software cannot write them,
    // so a mode switch clears the other layout to keep stale bits hidden
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chan
            always_comb begin
                next_status[g] = status[g];
                if (g == 0 && updown_count_enable) begin
                    next_status[g][tes_pkg::BIT_CMP0] = 1'b0;
                    next_status[g][tes_pkg::BIT_CMP1] = 1'b0;
                    if (count_step_i) begin
                        next_status[g][tes_pkg::BIT_STEP] = 1'b1;
                    end
                    if (updown_underflow_i) begin
                        next_status[g][tes_pkg::BIT_UDF] = 1'b1;
                    end
                    if (updown_overflow_i) begin
                        next_status[g][tes_pkg::BIT_OVF] = 1'b1;
                    end
                end else begin
                    next_status[g][tes_pkg::BIT_UDF] = 1'b0;
                    next_status[g][tes_pkg::BIT_STEP] = 1'b0;
                    if (compare0_match_i[g]) begin
                        next_status[g][tes_pkg::BIT_CMP0] = 1'b1;
                    end
                    if (compare1_match_i[g]) begin
                        next_status[g][tes_pkg::BIT_CMP1] = 1'b1;
                    end
                    if (upcount_overflow_i[g]) begin
                        next_status[g][tes_pkg::BIT_OVF] = 1'b1;
                    end
                end
                next_status[g][7:5] = 3'h0;
            end

            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    status[g] <= tes_pkg::STATUS_RESET;
                end else begin
                    status[g] <= next_status[g];
                end
            end

            // an interrupt event is every accepted pulse, not only a rising
            // flag: software never clears the flags, so a repeat match must
            // still reach the sticky interrupt status
            assign chan_event[g] = (g == 0 && updown_count_enable)
                ? (count_step_i | updown_underflow_i | updown_overflow_i)
                : (compare0_match_i[g] | compare1_match_i[g]
                    | upcount_overflow_i[g]);

            // per-channel checks; the event checks cover channel three only while in normal layout
            sequence s_norm_cmp0;
                !(g == 0 && updown_count_enable) && compare0_match_i[g];
            endsequence
            sequence s_norm_cmp1;
                !(g == 0 && updown_count_enable) && compare1_match_i[g];
            endsequence
            sequence s_norm_ovf;
                !(g == 0 && updown_count_enable) && upcount_overflow_i[g];
            endsequence
            AST_CHAN_CMP0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                s_norm_cmp0 |=> status[g][tes_pkg::BIT_CMP0] && irq_status[g])
                else $error("compare-0 match not flagged");
            AST_CHAN_CMP1: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                s_norm_cmp1 |=> status[g][tes_pkg::BIT_CMP1] && irq_status[g])
                else $error("compare-1 match not flagged");
            AST_CHAN_OVF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                s_norm_ovf |=> status[g][tes_pkg::BIT_OVF] && irq_status[g])
                else $error("up-counter overflow not flagged");
            AST_CHAN_UNUSED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                status[g][7:5] == 3'h0)
                else $error("unused status bits set");
            if (g > 0) begin : g_sticky
                // one layout only on these channels, so a flag never drops
                AST_STICKY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
                    ($past(status[g]) & ~status[g]) == 8'h00)
                    else $error("status flag dropped without reset");
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // control, interrupt and read data
    // ------------------------------------------------------------
    // reading a status register clears nothing: the flags mirror the
    // hardware record and only reset or a mode change drops them
    always_comb begin
        next_updown_count_enable = updown_count_enable;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_rdata = 32'h00000000;
        if (reg_wr_i) begin
            if (reg_addr_i == tes_pkg::OFS_MODE_CTRL) begin
                next_updown_count_enable = reg_wdata_i[tes_pkg::BIT_UDCE];
            end
            if (reg_addr_i == tes_pkg::OFS_IRQ_MASK) begin
                next_irq_mask = reg_wdata_i[tes_pkg::IRQ_W-1:0];
            end
            if (reg_addr_i == tes_pkg::OFS_IRQ_STATUS) begin
                next_irq_status = irq_status & ~reg_wdata_i[tes_pkg::IRQ_W-1:0];
            end
        end
        // set wins over a clear in the same cycle
        next_irq_status[N-1:0] = next_irq_status[N-1:0] | chan_event;
        next_irq_status[tes_pkg::IRQ_W-1:N] = '0;
        if (reg_rd_i) begin
            for (int i = 0; i < N; i++) begin
                if (reg_addr_i == tes_pkg::OFS_CHAN3_STATUS
                        + 32'(i) * tes_pkg::OFS_CHAN_STRIDE) begin
                    next_rdata = {24'h000000, status[i]};
                end
            end
            if (reg_addr_i == tes_pkg::OFS_MODE_CTRL) begin
                next_rdata = {31'h00000000, updown_count_enable};
            end
            if (reg_addr_i == tes_pkg::OFS_IRQ_STATUS) begin
                next_rdata = {24'h000000, irq_status};
            end
            if (reg_addr_i == tes_pkg::OFS_IRQ_MASK) begin
                next_rdata = {24'h000000, irq_mask};
            end
        end
        next_irq = |(next_irq_status & next_irq_mask);
        next_ovf_event = updown_count_enable && updown_overflow_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            updown_count_enable <= 1'b0;
            irq_mask <= tes_pkg::IRQ_RESET;
            irq_status <= tes_pkg::IRQ_RESET;
            reg_rdata_o <= 32'h00000000;
            irq_o <= 1'b0;
            updown_overflow_event_o <= 1'b0;
        end else begin
            updown_count_enable <= next_updown_count_enable;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            reg_rdata_o <= next_rdata;
            irq_o <= next_irq;
            updown_overflow_event_o <= next_ovf_event;
        end
    end

    assign updown_count_enable_o = updown_count_enable;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_step_seen;
        updown_count_enable && count_step_i;
    endsequence

    sequence s_udf_seen;
        updown_count_enable && updown_underflow_i;
    endsequence

    sequence s_udovf_seen;
        updown_count_enable && updown_overflow_i;
    endsequence

    // two-phase counter flags on channel three
    AST_STEP_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_step_seen ##1 updown_count_enable |-> status[0][tes_pkg::BIT_STEP])
        else $error("step did not set bit four");

    AST_STEP_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_step_seen |=> irq_status[0])
        else $error("step raised no interrupt event");

    AST_UDF_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        updown_count_enable && updown_underflow_i ##1 updown_count_enable
            |-> status[0][tes_pkg::BIT_UDF])
        else $error("underflow did not set bit three");

    AST_UDF_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_udf_seen |=> irq_status[0])
        else $error("underflow raised no interrupt event");

    AST_UDOVF_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        updown_count_enable && updown_overflow_i |=> status[0][tes_pkg::BIT_OVF]
            && updown_overflow_event_o)
        else $error("up/down overflow not flagged");

    AST_UDOVF_ONLY_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !updown_count_enable |=> !updown_overflow_event_o)
        else $error("overflow event outside two-phase mode");

    // layout of channel three in each mode
    AST_LAYOUT_TWO_PHASE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $past(updown_count_enable) |-> status[0][1:0] == 2'h0)
        else $error("compare bits seen in two-phase layout");

    AST_CMP_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        updown_count_enable && (compare0_match_i[0] || compare1_match_i[0])
            |=> status[0][1:0] == 2'h0)
        else $error("compare pulse flagged in two-phase layout");

    AST_LAYOUT_NORMAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !$past(updown_count_enable) |-> status[0][4:3] == 2'h0)
        else $error("counter bits seen in normal layout");

    AST_STEP_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !updown_count_enable && (count_step_i || updown_underflow_i)
            |=> status[0][4:3] == 2'h0)
        else $error("counter pulse flagged in normal layout");

    // register port: mode bit and read data
    AST_MODE_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == tes_pkg::OFS_MODE_CTRL
            |=> updown_count_enable_o == $past(reg_wdata_i[tes_pkg::BIT_UDCE]))
        else $error("mode bit did not take the written value");

    AST_RDATA_CHAN3: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == tes_pkg::OFS_CHAN3_STATUS
            |=> reg_rdata_o == {24'h000000, $past(status[0])})
        else $error("channel three status read back wrong");

    AST_RDATA_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data outside the read cycle");

    // normal channels and the interrupt
    AST_CMP0_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        compare0_match_i[1] |=> status[1][tes_pkg::BIT_CMP0] && irq_status[1])
        else $error("compare-0 match lost on channel four");

    AST_CMP1_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        compare1_match_i[4] |=> status[4][tes_pkg::BIT_CMP1])
        else $error("compare-1 match lost on channel seven");

    AST_OVF_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        upcount_overflow_i[2] |=> status[2][tes_pkg::BIT_OVF])
        else $error("overflow lost on channel five");

    AST_IRQ_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        irq_o == |(irq_status & irq_mask))
        else $error("interrupt line disagrees with status and mask");

    AST_WRITE_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        reg_wr_i && reg_addr_i == tes_pkg::OFS_CHAN4_STATUS && !compare0_match_i[1]
            && !compare1_match_i[1] && !upcount_overflow_i[1]
            |=> status[1] == $past(status[1]) && status[1][7:5] == 3'h0)
        else $error("write changed a status flag");
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
/*
 * self-checking bench for the timer event status block: event pulses,
 * status layouts of both modes, register port and interrupt.
 * assumes the design checks its own assertions; one clock, no partner.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [2:0] ch;
        logic [4:0] idx;
        logic [7:0] exp;
    } tes_row_t;
    // ------------------------------------------------------------
    // signals; events packed as cmp0, cmp1, ovf (5 each), step, udf, uovf
    // ------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [31:0] addr = 32'h00000000;
    logic [31:0] wdata = 32'h00000000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [17:0] evv = 18'h00000;
    logic [31:0] rdata;
    logic mode;
    logic uovf_ev;
    logic irq;
    int miscompares = 0;
    int n_tests = 0;
    // cumulative: flags are sticky, so each row adds to earlier ones
    tes_row_t rows [7] = '{'{3'h1, 5'h01, 8'h01}, '{3'h1, 5'h0B, 8'h05},
        '{3'h2, 5'h07, 8'h02}, '{3'h3, 5'h0D, 8'h04}, '{3'h4, 5'h04, 8'h01},
        '{3'h0, 5'h05, 8'h02}, '{3'h0, 5'h0F, 8'h02}};

    always #25 core_clk_i = ~core_clk_i;

    tes_event_status dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .compare0_match_i(evv[4:0]), .compare1_match_i(evv[9:5]),
        .upcount_overflow_i(evv[14:10]), .count_step_i(evv[15]),
        .updown_underflow_i(evv[16]), .updown_overflow_i(evv[17]),
        .updown_count_enable_o(mode), .updown_overflow_event_o(uovf_ev), .irq_o(irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge core_clk_i);
        wr_s <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
        @(posedge core_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk_i);
        rd_s <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask
    // one-cycle pulse; returns just after the edge that takes it
    task automatic ev(input int idx);
        @(posedge core_clk_i);
        evv <= 18'h00001 << idx;
        @(posedge core_clk_i);
        evv <= 18'h00000;
        #1;
    endtask
    function automatic logic [31:0] sta(input int ch);
        return tes_pkg::OFS_CHAN3_STATUS + ch * tes_pkg::OFS_CHAN_STRIDE;
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge core_clk_i);
        miscompares++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int c = 0; c < 5; c++) rd(sta(c), 32'h0, "status reset");
        chk("mode reset", mode, 1'b0);
        foreach (rows[i]) begin
            ev(rows[i].idx);
            rd(sta(rows[i].ch), {24'h0, rows[i].exp}, "status row");
        end
        chk("irq masked", irq, 1'b0);
        rd(tes_pkg::OFS_IRQ_STATUS, 32'h1F, "irq status");
        wr(sta(1), 32'hFF);
        rd(sta(1), 32'h05, "status write");
        rd(32'hFFFFF178, 32'h0, "unmapped");
        wr(tes_pkg::OFS_IRQ_MASK, 32'h1F);
        @(posedge core_clk_i);
        #1;
        chk("irq unmasked", irq, 1'b1);
        wr(tes_pkg::OFS_IRQ_STATUS, 32'h1F);
        @(posedge core_clk_i);
        #1;
        chk("irq cleared", irq, 1'b0);
        // a repeat match on a flag already set must still interrupt
        ev(1);
        chk("irq repeat", irq, 1'b1);
        wr(tes_pkg::OFS_IRQ_STATUS, 32'h1F);
        // two-phase mode: normal bits vanish, normal inputs ignored
        wr(tes_pkg::OFS_MODE_CTRL, 32'h1);
        #1;
        chk("mode on", mode, 1'b1);
        rd(sta(0), 32'h0, "chan3 mode1");
        ev(0);
        rd(sta(0), 32'h0, "chan3 cmp ignored");
        ev(15);
        chk("irq step", irq, 1'b1);
        rd(sta(0), 32'h10, "step flag");
        wr(tes_pkg::OFS_IRQ_STATUS, 32'h1F);
        #1;
        chk("irq clear two", irq, 1'b0);
        ev(16);
        chk("irq underflow", irq, 1'b1);
        rd(sta(0), 32'h18, "underflow flag");
        ev(17);
        chk("ovf event", uovf_ev, 1'b1);
        @(posedge core_clk_i);
        #1;
        chk("ovf event end", uovf_ev, 1'b0);
        rd(sta(0), 32'h1C, "ud overflow flag");
        // back to normal: step and underflow bits drop, shared bit 2 stays
        wr(tes_pkg::OFS_MODE_CTRL, 32'h0);
        rd(sta(0), 32'h04, "chan3 mode0");
        ev(0);
        rd(sta(0), 32'h05, "chan3 cmp0");
        // reset in mid-run clears every flag, the mode and the interrupt
        wr(tes_pkg::OFS_MODE_CTRL, 32'h1);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("mode rereset", mode, 1'b0);
        chk("irq rereset", irq, 1'b0);
        rd(sta(0), 32'h0, "chan3 rereset");
        rd(sta(1), 32'h0, "status rereset");
        end_of_test();
    end
endmodule
`default_nettype wire
